// ---- hw/anpc_regs.sv ----
// Per-port next page and port configuration register bank with an APB slave.
//
// Chosen here: the APB slave port.
`timescale 1ns/10ps
`default_nettype none

// Overview of operation
// - Transmit page more-pages flag is writable, resets to zero; zero marks last page.
// - Transmit page message flag is writable and resets to one.
// - Transmit page comply acknowledge flag is writable and resets to zero.
// - Transmit page toggle flag is writable and resets to zero.
// - Received page more-pages flag is read-only, resets to zero.
// - Received page acknowledge flag is read-only, resets to zero.
// - Received page message flag is read-only, copied from partner page.
// - Received page comply acknowledge flag is read-only, copied from partner page.
// - Received toggle and code field are read-only partner copies, reset zero.
// - Link test disable forces link pass on status and indicators.
// - Transmit disable turns off the twisted-pair transmitter.
// - Scrambler bypass routes 100 Mbps data around scrambler and descrambler.
// - Block code bypass routes 100 Mbps data around 4B/5B coding.
// - At 10 Mbps, jabber disable and heartbeat enable controls act.
// - 10 Mbps half-duplex loops data back unless loopback disable is set.
// - At 10 Mbps, carrier sense extend, reset one, holds carrier until receive valid falls.
// - Preamble control picks receive valid start at delimiter or carrier.
// - Serial mode delivers 10 Mbps receive data on bit zero.
// - Far end fault enable resets to one; clearing it stops indications.
// - Alternate next page control, reset zero, selects alternate handling.
// - Media select picks fiber when one; loaded once from the synchronised strap after reset release.
// - With alternate handling, page received also clears on inactive page or tx disable.
module anpc_regs #(
    parameter int ADDR_W = 8
) (
    // Clock and reset.
    input  wire logic              CLOCK,
    input  wire logic              RST,
    // APB slave.
    input  wire logic              PSEL,
    input  wire logic              PENABLE,
    input  wire logic              PWRITE,
    input  wire logic [ADDR_W-1:0] PADDR,
    input  wire logic [31:0]       PWDATA,
    input  wire logic [3:0]        PSTRB,
    output logic                   PREADY,
    output logic [31:0]            PRDATA,
    output logic                   PSLVERR,
    // Auto-negotiation engine, same clock.
    input  wire logic              PAGE_RX_STROBE,
    input  wire logic [15:0]       PAGE_RX_WORD,
    input  wire logic              PAGE_RX_ACTIVE,
    output logic [15:0]            NEXT_PAGE_WORD,
    // Port state, same clock.
    input  wire logic              LINK_OK,
    input  wire logic              SPEED_100,
    input  wire logic              FULL_DUPLEX,
    // Strap pin, asynchronous.
    input  wire logic              MEDIA_SELECT_STRAP,
    // Mode controls to the data path.
    output logic                   LINK_PASS,
    output logic                   TX_DISABLE,
    output logic                   SCRAMBLER_BYPASS,
    output logic                   BLOCK_CODE_BYPASS,
    output logic                   JABBER_DISABLE,
    output logic                   HEARTBEAT_ENABLE,
    output logic                   TP_LOOPBACK_ENABLE,
    output logic                   CRS_EXTEND,
    output logic                   PREAMBLE_DELIVER,
    output logic                   SERIAL_MODE,
    output logic                   FAR_END_FAULT_ENABLE,
    output logic                   ALT_NEXT_PAGE,
    output logic                   MEDIA_FIBER
);

    typedef struct packed {
        logic        strap_s1;
        logic        strap_s2;
        logic [1:0]  strap_cnt;
        logic [15:0] np_tx;
        logic [15:0] np_rx;
        logic [15:0] cfg;
        logic        page_rcvd;
        logic [31:0] rdata;
        logic        slverr;
    } anpc_state_t;

    localparam anpc_state_t STATE_RESET = '{
        strap_s1:  1'b0,
        strap_s2:  1'b0,
        strap_cnt: 2'h0,
        np_tx:     anpc_pkg::NP_TX_RESET,
        np_rx:     anpc_pkg::NP_RX_RESET,
        cfg:       anpc_pkg::CFG_RESET,
        page_rcvd: 1'b0,
        rdata:     32'h0000_0000,
        slverr:    1'b0
    };

    anpc_state_t s_q;
    anpc_state_t s_d;

    logic              setup;
    logic              access;
    logic [ADDR_W-1:0] a_tx;
    logic [ADDR_W-1:0] a_rx;
    logic [ADDR_W-1:0] a_cfg;
    logic [ADDR_W-1:0] a_st;
    logic              hit;
    logic [15:0]       rd_mux;
    logic [15:0]       wmask;
    logic              link_pass;
    logic              page_clr;

    // Bus phases and byte addresses of the four registers.
    assign setup  = PSEL & ~PENABLE;
    assign access = PSEL & PENABLE;
    assign a_tx   = ADDR_W'({anpc_pkg::IDX_NP_TX, 2'b00});
    assign a_rx   = ADDR_W'({anpc_pkg::IDX_NP_RX, 2'b00});
    assign a_cfg  = ADDR_W'({anpc_pkg::IDX_CFG, 2'b00});
    assign a_st   = ADDR_W'({anpc_pkg::IDX_STATUS, 2'b00});
    assign hit    = (PADDR == a_tx) | (PADDR == a_rx) | (PADDR == a_cfg) | (PADDR == a_st);
    assign wmask  = {{8{PSTRB[1]}}, {8{PSTRB[0]}}};

    // Forced pass overrides the judged link state.
    assign link_pass = s_q.cfg[anpc_pkg::CFG_LINK_TEST_DIS] | LINK_OK;

    // Read data selection; the status word holds the latched page flag and link state.
    always_comb
    begin
        rd_mux = 16'h0000;
        if (PADDR == a_tx)
        begin
            rd_mux = s_q.np_tx;
        end
        else if (PADDR == a_rx)
        begin
            rd_mux = s_q.np_rx;
        end
        else if (PADDR == a_cfg)
        begin
            rd_mux = s_q.cfg;
        end
        else if (PADDR == a_st)
        begin
            rd_mux[anpc_pkg::ST_PAGE_RCVD] = s_q.page_rcvd;
            rd_mux[anpc_pkg::ST_LINK_PASS] = link_pass;
        end
    end

    // Clear of the page received flag: on a read that reported it, or by page state under
    // alternate handling; a page that lands between capture and access is not lost.
    always_comb
    begin
        page_clr = access & ~PWRITE & (PADDR == a_st) &
                   s_q.rdata[anpc_pkg::ST_PAGE_RCVD];
        if (s_q.cfg[anpc_pkg::CFG_ALT_NP] &
            (~PAGE_RX_ACTIVE | s_q.cfg[anpc_pkg::CFG_TX_DIS]))
        begin
            page_clr = 1'b1;
        end
    end

    // Next state of the whole bank.
    always_comb
    begin
        s_d = s_q;
        // Strap pin passes two flops before anything reads it.
        s_d.strap_s1 = MEDIA_SELECT_STRAP;
        s_d.strap_s2 = s_q.strap_s1;
        // Read data and error are captured in the setup phase and held through access.
        if (setup)
        begin
            s_d.rdata  = {16'h0000, rd_mux};
            s_d.slverr = ~hit;
        end
        // Writes take effect at the access edge; received page and status ignore writes.
        if (access & PWRITE)
        begin
            if (PADDR == a_tx)
            begin
                s_d.np_tx = (s_q.np_tx & ~(wmask & anpc_pkg::NP_TX_WMASK)) |
                            (PWDATA[15:0] & wmask & anpc_pkg::NP_TX_WMASK);
            end
            if (PADDR == a_cfg)
            begin
                s_d.cfg = (s_q.cfg & ~wmask) | (PWDATA[15:0] & wmask);
            end
        end
        // The media select takes the synchronised strap once, after reset release.
        if (s_q.strap_cnt != 2'h3)
        begin
            s_d.strap_cnt = s_q.strap_cnt + 2'h1;
        end
        if (s_q.strap_cnt == anpc_pkg::STRAP_LOAD_AT)
        begin
            s_d.cfg[anpc_pkg::CFG_FIBER] = s_q.strap_s2;
        end
        // Partner page is copied whole when the engine reports it.
        if (PAGE_RX_STROBE)
        begin
            s_d.np_rx = PAGE_RX_WORD;
        end
        // A new page sets the flag; the set wins over a clear in the same cycle.
        s_d.page_rcvd = PAGE_RX_STROBE | (s_q.page_rcvd & ~page_clr);
    end

    // State register.
    always_ff @(posedge CLOCK or posedge RST)
    begin
        if (RST)
        begin
            s_q <= STATE_RESET;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    // Bus answers: zero wait states.
    assign PREADY  = 1'b1;
    assign PRDATA  = s_q.rdata;
    assign PSLVERR = s_q.slverr & access;

    // Mode controls, gated by the speed and duplex in which each one applies.
    assign NEXT_PAGE_WORD       = s_q.np_tx;
    assign LINK_PASS            = link_pass;
    assign TX_DISABLE           = s_q.cfg[anpc_pkg::CFG_TX_DIS];
    assign SCRAMBLER_BYPASS     = s_q.cfg[anpc_pkg::CFG_SCR_BYPASS] & SPEED_100;
    assign BLOCK_CODE_BYPASS    = s_q.cfg[anpc_pkg::CFG_CODE_BYPASS] & SPEED_100;
    assign JABBER_DISABLE       = s_q.cfg[anpc_pkg::CFG_JABBER_DIS] & ~SPEED_100;
    assign HEARTBEAT_ENABLE     = s_q.cfg[anpc_pkg::CFG_HEARTBEAT] & ~SPEED_100;
    assign TP_LOOPBACK_ENABLE   = ~s_q.cfg[anpc_pkg::CFG_LOOPBACK_DIS] & ~SPEED_100 &
                                  ~FULL_DUPLEX;
    assign CRS_EXTEND           = s_q.cfg[anpc_pkg::CFG_CRS_EXTEND] & ~SPEED_100;
    assign PREAMBLE_DELIVER     = s_q.cfg[anpc_pkg::CFG_PREAMBLE];
    assign SERIAL_MODE          = s_q.cfg[anpc_pkg::CFG_SERIAL_10M] & ~SPEED_100;
    assign FAR_END_FAULT_ENABLE = s_q.cfg[anpc_pkg::CFG_FAR_END_FAULT];
    assign ALT_NEXT_PAGE        = s_q.cfg[anpc_pkg::CFG_ALT_NP];
    assign MEDIA_FIBER          = s_q.cfg[anpc_pkg::CFG_FIBER];

    // Checks on the bank's own behaviour.
    default clocking cb @(posedge CLOCK);
    endclocking
    default disable iff (RST);

    a_tx_write_lands: assert property (
        access && PWRITE && PADDR == a_tx && PSTRB[1] |=>
        NEXT_PAGE_WORD[15] == $past(PWDATA[15]) && NEXT_PAGE_WORD[14] == 1'b0)
        else $error("Transmit page write did not land.");

    a_tx_holds_value: assert property (
        !(access && PWRITE && PADDR == a_tx) |=> $stable(NEXT_PAGE_WORD))
        else $error("Transmit page changed without a write.");

    a_rx_copies_page: assert property (
        PAGE_RX_STROBE |=> s_q.np_rx == $past(PAGE_RX_WORD))
        else $error("Received page not copied.");

    a_rx_read_only: assert property (
        !PAGE_RX_STROBE |=> $stable(s_q.np_rx))
        else $error("Received page changed without a page.");

    a_page_set_wins: assert property (
        PAGE_RX_STROBE |=> s_q.page_rcvd)
        else $error("Page received flag lost on set.");

    a_page_alt_clear: assert property (
        !PAGE_RX_STROBE && ALT_NEXT_PAGE && !PAGE_RX_ACTIVE |=> !s_q.page_rcvd)
        else $error("Page flag not cleared under alternate handling.");

    a_link_forced: assert property (
        s_q.cfg[anpc_pkg::CFG_LINK_TEST_DIS] |-> LINK_PASS)
        else $error("Link not forced to pass.");

    a_loopback_gate: assert property (
        TP_LOOPBACK_ENABLE |-> !SPEED_100 && !FULL_DUPLEX)
        else $error("Loopback outside 10 Mbps half duplex.");

    a_strap_loaded: assert property (
        s_q.strap_cnt == anpc_pkg::STRAP_LOAD_AT ##1 !(access && PWRITE && PADDR == a_cfg)
        |-> MEDIA_FIBER == $past(s_q.strap_s2))
        else $error("Media select not loaded from strap.");

    a_read_data_held: assert property (
        setup |=> PRDATA == {16'h0000, $past(rd_mux)})
        else $error("Read data not captured in the setup phase.");

    // Read data stands through the access cycle and after it.
    a_read_data_stands: assert property (
        setup ##1 access |=> $stable(PRDATA))
        else $error("Read data changed after the access cycle.");

    // Transmit page read returns the stored word.
    a_tx_read_data: assert property (
        setup && PADDR == a_tx |=> PRDATA[15:0] == $past(NEXT_PAGE_WORD))
        else $error("Transmit page read data wrong.");

    // All writable transmit page fields below the reserved bit land.
    a_tx_flags_land: assert property (
        access && PWRITE && PADDR == a_tx && PSTRB[1:0] == 2'b11 |=>
        NEXT_PAGE_WORD[13:0] == $past(PWDATA[13:0]))
        else $error("Transmit page fields did not land.");

    // The reserved transmit page bit never reads one.
    a_tx_reserved_zero: assert property (
        NEXT_PAGE_WORD[anpc_pkg::NP_ACK] == 1'b0)
        else $error("Reserved transmit page bit set.");

    // Received page read returns the stored partner word.
    a_rx_read_data: assert property (
        setup && PADDR == a_rx |=> PRDATA[15:0] == $past(s_q.np_rx))
        else $error("Received page read data wrong.");

    // Configuration read returns the stored word.
    a_cfg_read_data: assert property (
        setup && PADDR == a_cfg |=> PRDATA[15:0] == $past(s_q.cfg))
        else $error("Configuration read data wrong.");

    // A full-word configuration write lands once the strap has been taken.
    a_cfg_write_lands: assert property (
        access && PWRITE && PADDR == a_cfg && PSTRB[1:0] == 2'b11 && s_q.strap_cnt == 2'h3
        |=> s_q.cfg == $past(PWDATA[15:0]))
        else $error("Configuration write did not land.");

    // Status read reports the latched page flag and the link state.
    a_status_read: assert property (
        setup && PADDR == a_st |=> PRDATA[anpc_pkg::ST_PAGE_RCVD] == $past(s_q.page_rcvd) &&
        PRDATA[anpc_pkg::ST_LINK_PASS] == $past(LINK_PASS))
        else $error("Status read data wrong.");

    // A reported page clears on its read unless a new page lands.
    a_page_read_clear: assert property (
        access && !PWRITE && PADDR == a_st && s_q.rdata[anpc_pkg::ST_PAGE_RCVD] &&
        !PAGE_RX_STROBE |=> !s_q.page_rcvd)
        else $error("Page flag not cleared by its read.");

    // A page not yet reported survives a read under standard handling.
    a_page_not_lost: assert property (
        s_q.page_rcvd && !s_q.rdata[anpc_pkg::ST_PAGE_RCVD] && !ALT_NEXT_PAGE |=>
        s_q.page_rcvd)
        else $error("Unreported page flag lost.");

    // Transmit disable clears the flag under alternate handling.
    a_tx_dis_clear: assert property (
        ALT_NEXT_PAGE && TX_DISABLE && !PAGE_RX_STROBE |=> !s_q.page_rcvd)
        else $error("Page flag not cleared by transmit disable.");

    // Alternate handling alone does not clear an active, unread page.
    a_alt_keeps_page: assert property (
        ALT_NEXT_PAGE && PAGE_RX_ACTIVE && !TX_DISABLE && s_q.page_rcvd &&
        !(access && !PWRITE && PADDR == a_st) |=> s_q.page_rcvd)
        else $error("Page flag cleared while active.");

    // Bypass controls act only at 100 Mbps.
    a_bypass_gate: assert property (
        SCRAMBLER_BYPASS || BLOCK_CODE_BYPASS |-> SPEED_100)
        else $error("Bypass active at 10 Mbps.");

    // At 100 Mbps the bypass controls follow their bits.
    a_hundred_pass: assert property (
        SPEED_100 |-> SCRAMBLER_BYPASS == s_q.cfg[anpc_pkg::CFG_SCR_BYPASS] &&
        BLOCK_CODE_BYPASS == s_q.cfg[anpc_pkg::CFG_CODE_BYPASS])
        else $error("Bypass control does not follow its bit.");

    // The 10 Mbps controls stay off at 100 Mbps.
    a_ten_meg_gate: assert property (
        JABBER_DISABLE || HEARTBEAT_ENABLE || CRS_EXTEND || SERIAL_MODE |-> !SPEED_100)
        else $error("10 Mbps control active at 100 Mbps.");

    // At 10 Mbps the jabber and serial controls follow their bits.
    a_ten_meg_pass: assert property (
        !SPEED_100 |-> JABBER_DISABLE == s_q.cfg[anpc_pkg::CFG_JABBER_DIS] &&
        SERIAL_MODE == s_q.cfg[anpc_pkg::CFG_SERIAL_10M])
        else $error("10 Mbps control does not follow its bit.");

    // Loopback is on by default in 10 Mbps half duplex.
    a_loopback_default: assert property (
        !SPEED_100 && !FULL_DUPLEX && !s_q.cfg[anpc_pkg::CFG_LOOPBACK_DIS] |->
        TP_LOOPBACK_ENABLE)
        else $error("Default loopback missing.");

    c_tx_write: cover property (access && PWRITE && PADDR == a_tx);
    c_page_read: cover property (s_q.page_rcvd ##1 access && !PWRITE && PADDR == a_st);
    c_set_and_clear: cover property (PAGE_RX_STROBE && page_clr);
    c_fiber_strap: cover property (s_q.strap_cnt == anpc_pkg::STRAP_LOAD_AT && s_q.strap_s2);
    c_alt_tx_clear: cover property (ALT_NEXT_PAGE && TX_DISABLE && s_q.page_rcvd);

endmodule

`default_nettype wire

// ---- hw/anpc_pkg.sv ----
// Package with register map, field positions and reset values of the port register bank.
package anpc_pkg;

    // Register indices; the byte address on the bus is four times the index.
    localparam logic [5:0] IDX_NP_TX  = 6'h07;
    localparam logic [5:0] IDX_NP_RX  = 6'h08;
    localparam logic [5:0] IDX_CFG    = 6'h10;
    localparam logic [5:0] IDX_STATUS = 6'h06;

    // Reset values.
    localparam logic [15:0] NP_TX_RESET = 16'h2001;
    localparam logic [15:0] NP_RX_RESET = 16'h0000;
    localparam logic [15:0] CFG_RESET   = 16'h0084;

    // Writable bits of the next page transmit register; bit 14 is reserved.
    localparam logic [15:0] NP_TX_WMASK = 16'hBFFF;

    // Next page word field positions.
    localparam int NP_MORE_PAGES  = 15;
    localparam int NP_ACK         = 14;
    localparam int NP_MESSAGE     = 13;
    localparam int NP_COMPLY_ACK  = 12;
    localparam int NP_TOGGLE      = 11;

    // Port configuration field positions.
    localparam int CFG_LINK_TEST_DIS = 14;
    localparam int CFG_TX_DIS        = 13;
    localparam int CFG_SCR_BYPASS    = 12;
    localparam int CFG_CODE_BYPASS   = 11;
    localparam int CFG_JABBER_DIS    = 10;
    localparam int CFG_HEARTBEAT     = 9;
    localparam int CFG_LOOPBACK_DIS  = 8;
    localparam int CFG_CRS_EXTEND    = 7;
    localparam int CFG_PREAMBLE      = 5;
    localparam int CFG_SERIAL_10M    = 3;
    localparam int CFG_FAR_END_FAULT = 2;
    localparam int CFG_ALT_NP        = 1;
    localparam int CFG_FIBER         = 0;

    // Status register field positions.
    localparam int ST_PAGE_RCVD = 1;
    localparam int ST_LINK_PASS = 2;

    // Cycle count of the strap counter at which the synchronised strap is loaded.
    localparam logic [1:0] STRAP_LOAD_AT = 2'h2;

endpackage

// ---- tb/anpc_partner.sv ----
// Behavioural auto-negotiation engine that hands received partner pages to the bank.
`timescale 1ns/10ps
`default_nettype none

module anpc_partner (
    // Clock.
    input  wire logic        CLOCK,
    // Received page hand-over.
    output logic             PAGE_RX_STROBE,
    output logic [15:0]      PAGE_RX_WORD,
    output logic             PAGE_RX_ACTIVE
);
    // Idle state: no strobe, page variable true.
    initial
    begin
        PAGE_RX_STROBE = 1'b0;
        PAGE_RX_WORD   = 16'h0000;
        PAGE_RX_ACTIVE = 1'b1;
    end

    // One page for one cycle; afterwards the word lines show the inverse so a late copy is seen.
    task automatic send(input logic [15:0] w);
        @(posedge CLOCK);
        PAGE_RX_STROBE <= 1'b1;
        PAGE_RX_WORD   <= w;
        @(posedge CLOCK);
        PAGE_RX_STROBE <= 1'b0;
        PAGE_RX_WORD   <= ~w;
    endtask

    // Sets the page received variable of the engine.
    task automatic set_active(input logic a);
        @(posedge CLOCK);
        PAGE_RX_ACTIVE <= a;
    endtask
endmodule

`default_nettype wire

// ---- tb/aneg_next_page_port_config_tb.sv ----
// Self-checking bench for the next page and port configuration register bank.
`timescale 1ns/10ps
`default_nettype none

module aneg_next_page_port_config_tb;
    logic        clock = 1'b0;
    logic        rst = 1'b1;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic        pready;
    logic [31:0] prdata;
    logic        pslverr;
    logic        strobe;
    logic        active;
    logic [15:0] word;
    logic [15:0] np_word;
    logic        link_ok = 1'b0;
    logic        spd = 1'b0;
    logic        fdx = 1'b0;
    logic        strap = 1'b1;
    logic [12:0] modes;
    logic [32:0] exp_q[$];
    logic [15:0] w;
    logic [32:0] note;
    int          n_mismatch = 0;
    int          n_compared = 0;
    int          cyc = 0;
    int unsigned r;

    // Clock of 10 ns period.
    always #5 clock = ~clock;

    anpc_regs i_anpc_regs (
        .CLOCK(clock), .RST(rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
        .PADDR(paddr), .PWDATA(pwdata), .PSTRB(4'hF), .PREADY(pready), .PRDATA(prdata),
        .PSLVERR(pslverr), .PAGE_RX_STROBE(strobe), .PAGE_RX_WORD(word),
        .PAGE_RX_ACTIVE(active), .NEXT_PAGE_WORD(np_word), .LINK_OK(link_ok),
        .SPEED_100(spd), .FULL_DUPLEX(fdx), .MEDIA_SELECT_STRAP(strap),
        .LINK_PASS(modes[12]), .TX_DISABLE(modes[11]), .SCRAMBLER_BYPASS(modes[10]),
        .BLOCK_CODE_BYPASS(modes[9]), .JABBER_DISABLE(modes[8]),
        .HEARTBEAT_ENABLE(modes[7]), .TP_LOOPBACK_ENABLE(modes[6]), .CRS_EXTEND(modes[5]),
        .PREAMBLE_DELIVER(modes[4]), .SERIAL_MODE(modes[3]),
        .FAR_END_FAULT_ENABLE(modes[2]), .ALT_NEXT_PAGE(modes[1]), .MEDIA_FIBER(modes[0]));

    anpc_partner i_anpc_partner (
        .CLOCK(clock), .PAGE_RX_STROBE(strobe), .PAGE_RX_WORD(word), .PAGE_RX_ACTIVE(active));

    // Compares one value and counts the outcome.
    task automatic chk(input logic [32:0] got, input logic [32:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Prints the verdict and ends the run.
    task automatic final_report();
        if (n_mismatch == 0 && n_compared > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // One APB transfer; the expected error flag and read data are noted first.
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       input logic [32:0] exp);
        exp_q.push_back(exp);
        @(posedge clock);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        do @(posedge clock); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Takes the oldest note at each completed transfer; writes check only the error flag.
    always @(posedge clock)
    begin
        if (psel && penable && pready === 1'b1 && exp_q.size() > 0)
        begin
            note = exp_q.pop_front();
            if (pwrite)
                chk({pslverr, 32'h0000_0000}, {note[32], 32'h0000_0000});
            else
                chk({pslverr, prdata}, note);
        end
    end

    // Cuts a hang short.
    always @(posedge clock)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            n_mismatch++;
            final_report();
        end
    end

    // Main sequence.
    initial
    begin
        r = $urandom(56);
        repeat (3) @(posedge clock);
        rst <= 1'b0;
        repeat (4) @(posedge clock);
        // Reset values, media select taken from the strap.
        apb(0, 8'h1c, 0, {1'b0, 32'h0000_2001});
        apb(0, 8'h20, 0, {1'b0, 32'h0000_0000});
        apb(0, 8'h40, 0, {1'b0, 32'h0000_0085});
        // Transmit page write; the reserved bit stays zero.
        w = 16'($urandom()) | 16'h4000;
        apb(1, 8'h1c, {16'h0000, w}, {1'b0, 32'h0000_0000});
        apb(0, 8'h1c, 0, {1'b0, 16'h0000, w & anpc_pkg::NP_TX_WMASK});
        chk({17'h0_0000, np_word}, {17'h0_0000, w & anpc_pkg::NP_TX_WMASK});
        // A write to the received page draws no error; an unmapped place errors.
        apb(1, 8'h20, 32'h0000_FFFF, {1'b0, 32'h0000_0000});
        apb(1, 8'h3c, 32'h0000_FFFF, {1'b1, 32'h0000_0000});
        apb(0, 8'h3c, 0, {1'b1, 32'h0000_0000});
        // Partner page copied; page flag clears on read.
        link_ok <= 1'b1;
        w = 16'($urandom());
        i_anpc_partner.send(w);
        apb(0, 8'h20, 0, {1'b0, 16'h0000, w});
        apb(0, 8'h18, 0, {1'b0, 32'h0000_0006});
        apb(0, 8'h18, 0, {1'b0, 32'h0000_0004});
        // Alternate handling: flag kept while active, dropped when the variable goes false.
        apb(1, 8'h40, 32'h0000_0087, {1'b0, 32'h0000_0000});
        i_anpc_partner.send(16'h1234);
        apb(0, 8'h18, 0, {1'b0, 32'h0000_0006});
        i_anpc_partner.send(16'h4321);
        i_anpc_partner.set_active(1'b0);
        @(posedge clock);
        apb(0, 8'h18, 0, {1'b0, 32'h0000_0004});
        i_anpc_partner.set_active(1'b1);
        // Random configurations across speed and duplex.
        for (int i = 0; i < 12; i++)
        begin
            w = 16'($urandom());
            link_ok <= 1'($urandom());
            spd <= 1'(i);
            fdx <= 1'(i >> 1);
            apb(1, 8'h40, {16'h0000, w}, {1'b0, 32'h0000_0000});
            apb(0, 8'h40, 0, {1'b0, 16'h0000, w});
            chk({20'h0_0000, modes}, {20'h0_0000, w[14] | link_ok, w[13], w[12] & spd,
                w[11] & spd, w[10] & ~spd, w[9] & ~spd, ~w[8] & ~spd & ~fdx, w[7] & ~spd,
                w[5], w[3] & ~spd, w[2], w[1], w[0]});
        end
        repeat (3) @(posedge clock);
        final_report();
    end
endmodule

`default_nettype wire
